// file: bcs_top.sv
`timescale 1ns/1ps
`include "bcs_consts.svh"

// Functional notes
// - Hall pair high when positive exceeds negative
// - Forward table gives source, sink, float
// - Reverse swaps source and sink roles
// - Two pins pick first divisor or external
// - Third pin picks 5/4/3 second divisor
// - External mode uses reference undivided
// - Lock indicator pulls on while locked
// - Amp node low stops drive, free-run
// - Stop holds regardless of brake input
// - Brake command high applies braking
// - Brake onset while turning: full reverse torque
// - Taper below locked speed over 32/8/2
// - Feedback tied high: first Hall feeds speed
// - Feedback tied low: three-Hall composite
// - Otherwise tachometer amplifier feeds speed
module bcs_top #(
	parameter logic [`BCS_CNT_W-1:0] STALL_CYCLES = `BCS_CNT_W'(`BCS_STALL_TIME_US * `BCS_CLK_MHZ)
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic [`BCS_HALL_W-1:0] hall_sense_a_pos,
	input wire logic [`BCS_HALL_W-1:0] hall_sense_a_neg,
	input wire logic [`BCS_HALL_W-1:0] hall_sense_b_pos,
	input wire logic [`BCS_HALL_W-1:0] hall_sense_b_neg,
	input wire logic [`BCS_HALL_W-1:0] hall_sense_c_pos,
	input wire logic [`BCS_HALL_W-1:0] hall_sense_c_neg,
	input wire logic dir_reverse,
	input wire logic [1:0] divisor_select_a,
	input wire logic [1:0] divisor_select_b,
	input wire logic [1:0] divisor_select_c,
	input wire logic reference_oscillator_input,
	input wire logic [1:0] speed_feedback_input,
	input wire logic speed_amp_output,
	input wire logic tach_pulse,
	input wire logic brake_command,
	output bcs_pkg::bcs_drive_e phase_drive_a,
	output bcs_pkg::bcs_drive_e phase_drive_b,
	output bcs_pkg::bcs_drive_e phase_drive_c,
	output logic lock_indicator_out,
	output logic lock_indicator_oe,
	output logic speed_pulse_output_out,
	output logic speed_pulse_output_oe,
	output logic stop_mode,
	output logic brake_active,
	output logic brake_taper_threshold
);

	logic [`BCS_HALL_W-1:0] hall_pos [3];
	logic [`BCS_HALL_W-1:0] hall_neg [3];
	logic [2:0] hall, next_hall;
	logic ref_prev, fb_prev, next_fb_prev;
	logic brake_prev;
	logic ref_edge, fb_sig, fb_edge;
	logic servo_tick, locked, turning, below_taper;
	bcs_pkg::bcs_fb_mode_e fb_mode;
	bcs_pkg::bcs_state_e state, next_state;
	bcs_pkg::bcs_drive_e next_a, next_b, next_c;
	logic next_stop, next_brake, next_taper, next_lock_oe, next_pulse_oe;
	logic rev_eff;
	logic [5:0] drv;

	assign hall_pos[0] = hall_sense_a_pos;
	assign hall_pos[1] = hall_sense_b_pos;
	assign hall_pos[2] = hall_sense_c_pos;
	assign hall_neg[0] = hall_sense_a_neg;
	assign hall_neg[1] = hall_sense_b_neg;
	assign hall_neg[2] = hall_sense_c_neg;

	// ----------------------------------------
	// Hall comparators
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_hall
			assign next_hall[gi] = (hall_pos[gi] > hall_neg[gi]);
		end
	endgenerate

	// ----------------------------------------
	// Feedback source and edges
	// ----------------------------------------
	always_comb
	begin
		case (speed_feedback_input)
			bcs_pkg::LVL_LOW: fb_mode = bcs_pkg::FB_TRIPLE;
			bcs_pkg::LVL_MID: fb_mode = bcs_pkg::FB_AMP;
			default: fb_mode = bcs_pkg::FB_SINGLE;
		endcase
		case (fb_mode)
			bcs_pkg::FB_SINGLE: fb_sig = hall[0];
			bcs_pkg::FB_TRIPLE: fb_sig = ^hall;
			default: fb_sig = tach_pulse;
		endcase
		next_fb_prev = fb_sig;
		fb_edge = fb_sig && !fb_prev;
		ref_edge = reference_oscillator_input && !ref_prev;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			hall <= 3'h0;
			fb_prev <= 1'b0;
			ref_prev <= 1'b0;
			brake_prev <= 1'b0;
		end
		else if (clk_en)
		begin
			hall <= next_hall;
			fb_prev <= next_fb_prev;
			ref_prev <= reference_oscillator_input;
			brake_prev <= brake_command;
		end
	end

	bcs_ref_divider u_div (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.ref_edge(ref_edge),
		.sel_a(divisor_select_a),
		.sel_b(divisor_select_b),
		.sel_c(divisor_select_c),
		.servo_tick(servo_tick)
	);

	bcs_speed_monitor #(.STALL_CYCLES(STALL_CYCLES)) u_speed (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.servo_tick(servo_tick),
		.fb_edge(fb_edge),
		.fb_mode(fb_mode),
		.locked(locked),
		.turning(turning),
		.below_taper(below_taper)
	);

	// ----------------------------------------
	// Brake sequence
	// ----------------------------------------
	always_comb
	begin
		next_state = state;
		case (state)
			bcs_pkg::ST_RUN:
			begin
				if (brake_command && !brake_prev && turning)
					next_state = bcs_pkg::ST_BRAKE_FULL;
				// brake high with motor still halts
				else if (brake_command && !turning)
					next_state = bcs_pkg::ST_HALT;
			end
			bcs_pkg::ST_BRAKE_FULL:
			begin
				if (!brake_command)
					next_state = bcs_pkg::ST_RUN;
				else if (below_taper)
					next_state = bcs_pkg::ST_BRAKE_TAPER;
			end
			bcs_pkg::ST_BRAKE_TAPER:
			begin
				if (!brake_command)
					next_state = bcs_pkg::ST_RUN;
				else if (!turning)
					next_state = bcs_pkg::ST_HALT;
			end
			default:
			begin
				if (!brake_command)
					next_state = bcs_pkg::ST_RUN;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			state <= bcs_pkg::ST_RUN;
		else if (clk_en)
			state <= next_state;
	end

	// ----------------------------------------
	// Commutation and pin outputs
	// ----------------------------------------
	always_comb
	begin
		// Braking drives the table opposite to dir_reverse for reverse torque
		rev_eff = dir_reverse ^ ((state == bcs_pkg::ST_BRAKE_FULL)
			|| (state == bcs_pkg::ST_BRAKE_TAPER));
		case (hall)
			3'h3: drv = {bcs_pkg::DRV_FLOAT, bcs_pkg::DRV_SOURCE, bcs_pkg::DRV_SINK};
			3'h1: drv = {bcs_pkg::DRV_SOURCE, bcs_pkg::DRV_FLOAT, bcs_pkg::DRV_SINK};
			3'h5: drv = {bcs_pkg::DRV_SOURCE, bcs_pkg::DRV_SINK, bcs_pkg::DRV_FLOAT};
			3'h4: drv = {bcs_pkg::DRV_FLOAT, bcs_pkg::DRV_SINK, bcs_pkg::DRV_SOURCE};
			3'h6: drv = {bcs_pkg::DRV_SINK, bcs_pkg::DRV_FLOAT, bcs_pkg::DRV_SOURCE};
			3'h2: drv = {bcs_pkg::DRV_SINK, bcs_pkg::DRV_SOURCE, bcs_pkg::DRV_FLOAT};
			default: drv = {3{bcs_pkg::DRV_FLOAT}};
		endcase
		// reverse swaps source and sink
		// Swapping the two bits of a field exchanges source and sink; float stays
		if (rev_eff)
			drv = {drv[4], drv[5], drv[2], drv[3], drv[0], drv[1]};
		next_stop = !speed_amp_output;
		if (next_stop || state == bcs_pkg::ST_HALT)
			drv = {3{bcs_pkg::DRV_FLOAT}};
		next_a = bcs_pkg::bcs_drive_e'(drv[5:4]);
		next_b = bcs_pkg::bcs_drive_e'(drv[3:2]);
		next_c = bcs_pkg::bcs_drive_e'(drv[1:0]);
		next_brake = (state != bcs_pkg::ST_RUN) && !next_stop;
		next_taper = below_taper;
		next_lock_oe = locked;
		next_pulse_oe = !fb_sig;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			phase_drive_a <= bcs_pkg::DRV_FLOAT;
			phase_drive_b <= bcs_pkg::DRV_FLOAT;
			phase_drive_c <= bcs_pkg::DRV_FLOAT;
			stop_mode <= 1'b0;
			brake_active <= 1'b0;
			brake_taper_threshold <= 1'b0;
			lock_indicator_oe <= 1'b0;
			speed_pulse_output_oe <= 1'b0;
		end
		else if (clk_en)
		begin
			phase_drive_a <= next_a;
			phase_drive_b <= next_b;
			phase_drive_c <= next_c;
			stop_mode <= next_stop;
			brake_active <= next_brake;
			brake_taper_threshold <= next_taper;
			lock_indicator_oe <= next_lock_oe;
			speed_pulse_output_oe <= next_pulse_oe;
		end
	end

	// Open-collector pins only ever pull low
	assign lock_indicator_out = 1'b0;
	assign speed_pulse_output_out = 1'b0;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	hall_resolve_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		clk_en |=> hall[0] == $past(hall_sense_a_pos > hall_sense_a_neg))
		else $error("hall a not resolved by comparison");
	fwd_pattern_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		(clk_en && hall == 3'h3 && !dir_reverse && speed_amp_output && state == bcs_pkg::ST_RUN)
		|=> (phase_drive_a == bcs_pkg::DRV_FLOAT && phase_drive_b == bcs_pkg::DRV_SOURCE
		&& phase_drive_c == bcs_pkg::DRV_SINK))
		else $error("forward commutation pattern wrong");
	rev_pattern_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		(clk_en && hall == 3'h3 && dir_reverse && speed_amp_output && state == bcs_pkg::ST_RUN)
		|=> (phase_drive_a == bcs_pkg::DRV_FLOAT && phase_drive_b == bcs_pkg::DRV_SINK
		&& phase_drive_c == bcs_pkg::DRV_SOURCE))
		else $error("reverse commutation pattern wrong");
	stop_float_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		stop_mode |-> (phase_drive_a == bcs_pkg::DRV_FLOAT && phase_drive_b == bcs_pkg::DRV_FLOAT
		&& phase_drive_c == bcs_pkg::DRV_FLOAT))
		else $error("drive active in stop mode");
	stop_entry_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		(clk_en && !speed_amp_output) |=> (stop_mode && !brake_active))
		else $error("amp node low did not force stop");
	lock_pin_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		clk_en |=> lock_indicator_oe == $past(locked))
		else $error("lock pin does not follow lock");
	brake_onset_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		(clk_en && state == bcs_pkg::ST_RUN && brake_command && !brake_prev && turning)
		|=> state == bcs_pkg::ST_BRAKE_FULL)
		else $error("brake onset did not start full reverse torque");
	taper_entry_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		(clk_en && state == bcs_pkg::ST_BRAKE_FULL && brake_command && below_taper)
		|=> state == bcs_pkg::ST_BRAKE_TAPER)
		else $error("taper not entered below threshold");
	fb_select_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		(speed_feedback_input == bcs_pkg::LVL_HIGH) |-> fb_sig == hall[0])
		else $error("single hall feedback not selected");

endmodule // bcs_top

// file: bcs_consts.svh
`ifndef BCS_CONSTS_SVH
`define BCS_CONSTS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define BCS_CLK_MHZ 200
`define BCS_STALL_TIME_US 10000

// ----------------------------------------
// Widths
// ----------------------------------------
`define BCS_HALL_W 8
`define BCS_DIV_W 17
`define BCS_CNT_W 24

// ----------------------------------------
// Divider figures
// ----------------------------------------
`define BCS_DIV1_BASE 17'h00080
`define BCS_DIV2_LOW 3'h5
`define BCS_DIV2_MID 3'h4
`define BCS_DIV2_HIGH 3'h3
`define BCS_LEVEL_STEPS 4'h3
`define BCS_EXT_INDEX 4'h0

// ----------------------------------------
// Lock tolerance and taper shifts
// ----------------------------------------
`define BCS_LOCK_TOL_SHIFT 4
`define BCS_TAPER_SHIFT_AMP 5
`define BCS_TAPER_SHIFT_TRIPLE 3
`define BCS_TAPER_SHIFT_SINGLE 1

`endif

// file: bcs_pkg.sv
package bcs_pkg;

	// Three-level pin code; 2'h3 is decoded as high
	typedef enum logic [1:0] {
		LVL_LOW = 2'h0,
		LVL_MID = 2'h1,
		LVL_HIGH = 2'h2
	} bcs_level_e;

	// Per-phase output state
	typedef enum logic [1:0] {
		DRV_FLOAT = 2'h0,
		DRV_SOURCE = 2'h1,
		DRV_SINK = 2'h2
	} bcs_drive_e;

	// Speed feedback source
	typedef enum logic [1:0] {
		FB_AMP = 2'h0,
		FB_TRIPLE = 2'h1,
		FB_SINGLE = 2'h2
	} bcs_fb_mode_e;

	// Brake sequence, Gray along run -> full -> taper -> halt
	typedef enum logic [1:0] {
		ST_RUN = 2'h0,
		ST_BRAKE_FULL = 2'h1,
		ST_BRAKE_TAPER = 2'h3,
		ST_HALT = 2'h2
	} bcs_state_e;

endpackage

// file: bcs_ref_divider.sv
`timescale 1ns/1ps
`include "bcs_consts.svh"

module bcs_ref_divider (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic ref_edge,
	input wire logic [1:0] sel_a,
	input wire logic [1:0] sel_b,
	input wire logic [1:0] sel_c,
	output logic servo_tick
);

	logic [`BCS_DIV_W-1:0] cnt;
	logic [`BCS_DIV_W-1:0] next_cnt;
	logic next_tick;
	logic ext_mode;
	logic [3:0] idx;
	logic [2:0] div2;
	logic [`BCS_DIV_W-1:0] div1;
	logic [`BCS_DIV_W-1:0] total;

	function automatic logic [1:0] lvl(input logic [1:0] code);
		lvl = (code == bcs_pkg::LVL_LOW) ? 2'h0 : (code == bcs_pkg::LVL_MID) ? 2'h1 : 2'h2;
	endfunction

	// ----------------------------------------
	// Divisor decode and count
	// ----------------------------------------
	always_comb
	begin
		idx = 4'({2'h0, lvl(sel_a)} * `BCS_LEVEL_STEPS) + {2'h0, lvl(sel_b)};
		ext_mode = (idx == `BCS_EXT_INDEX);
		div1 = ext_mode ? `BCS_DIV1_BASE : `BCS_DIV_W'(`BCS_DIV1_BASE << (idx - 4'h1));
		case (lvl(sel_c))
			2'h0: div2 = `BCS_DIV2_LOW;
			2'h1: div2 = `BCS_DIV2_MID;
			default: div2 = `BCS_DIV2_HIGH;
		endcase
		total = `BCS_DIV_W'(div1 * {{(`BCS_DIV_W-3){1'b0}}, div2});
		next_cnt = cnt;
		next_tick = 1'b0;
		if (ext_mode)
		begin
			next_cnt = '0;
			next_tick = ref_edge;
		end
		else if (ref_edge)
		begin
			if (cnt >= total - `BCS_DIV_W'(1))
			begin
				next_cnt = '0;
				next_tick = 1'b1;
			end
			else
			begin
				next_cnt = cnt + `BCS_DIV_W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt <= '0;
			servo_tick <= 1'b0;
		end
		else if (clk_en)
		begin
			cnt <= next_cnt;
			servo_tick <= next_tick;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	ext_tick_pass_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		(clk_en && ext_mode && ref_edge) |=> servo_tick)
		else $error("external reference edge not passed to servo tick");
	tick_from_edge_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		$rose(servo_tick) |-> $past(ref_edge && clk_en))
		else $error("servo tick without reference edge");
	div_wrap_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		(clk_en && !ext_mode && ref_edge && cnt == total - `BCS_DIV_W'(1)) |=> (cnt == '0 && servo_tick))
		else $error("divider did not wrap at total divisor");

endmodule // bcs_ref_divider

// file: bcs_speed_monitor.sv
`timescale 1ns/1ps
`include "bcs_consts.svh"

module bcs_speed_monitor #(
	parameter logic [`BCS_CNT_W-1:0] STALL_CYCLES = `BCS_CNT_W'(`BCS_STALL_TIME_US * `BCS_CLK_MHZ)
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic servo_tick,
	input wire logic fb_edge,
	input wire bcs_pkg::bcs_fb_mode_e fb_mode,
	output logic locked,
	output logic turning,
	output logic below_taper
);

	logic [`BCS_CNT_W-1:0] srv_cnt, srv_period, fb_cnt, fb_period, locked_period;
	logic [`BCS_CNT_W-1:0] next_srv_cnt, next_srv_period, next_fb_cnt, next_fb_period;
	logic [`BCS_CNT_W-1:0] next_locked_period, diff, slow;
	logic next_locked, next_turning, next_below;
	logic [31:0] threshold;

	// ----------------------------------------
	// Period measurement and lock
	// ----------------------------------------
	always_comb
	begin
		next_srv_cnt = (srv_cnt == STALL_CYCLES) ? srv_cnt : srv_cnt + `BCS_CNT_W'(1);
		next_srv_cnt = servo_tick ? '0 : next_srv_cnt;
		next_srv_period = servo_tick ? srv_cnt : srv_period;
		next_fb_cnt = (fb_cnt == STALL_CYCLES) ? fb_cnt : fb_cnt + `BCS_CNT_W'(1);
		next_fb_cnt = fb_edge ? '0 : next_fb_cnt;
		next_fb_period = fb_edge ? fb_cnt : fb_period;
		next_turning = (fb_cnt < STALL_CYCLES);
		diff = (fb_period > srv_period) ? fb_period - srv_period : srv_period - fb_period;
		next_locked = turning && (srv_period != '0) && (srv_period != STALL_CYCLES)
			&& (diff <= (srv_period >> `BCS_LOCK_TOL_SHIFT));
		next_locked_period = locked ? fb_period : locked_period;
		// taper below locked speed over 32, 8 or 2
		case (fb_mode)
			bcs_pkg::FB_SINGLE: threshold = {8'h00, locked_period} << `BCS_TAPER_SHIFT_SINGLE;
			bcs_pkg::FB_TRIPLE: threshold = {8'h00, locked_period} << `BCS_TAPER_SHIFT_TRIPLE;
			default: threshold = {8'h00, locked_period} << `BCS_TAPER_SHIFT_AMP;
		endcase
		slow = (fb_cnt > fb_period) ? fb_cnt : fb_period;
		next_below = (locked_period != '0) && ({8'h00, slow} > threshold);
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			srv_cnt <= '0;
			srv_period <= '0;
			fb_cnt <= '0;
			fb_period <= '0;
			locked_period <= '0;
			locked <= 1'b0;
			turning <= 1'b0;
			below_taper <= 1'b0;
		end
		else if (clk_en)
		begin
			srv_cnt <= next_srv_cnt;
			srv_period <= next_srv_period;
			fb_cnt <= next_fb_cnt;
			fb_period <= next_fb_period;
			locked_period <= next_locked_period;
			locked <= next_locked;
			turning <= next_turning;
			below_taper <= next_below;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	stall_stops_turn_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		(clk_en && fb_cnt == STALL_CYCLES) |=> !turning)
		else $error("turning flag held after feedback stall");
	lock_needs_turn_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		$rose(locked) |-> $past(turning))
		else $error("lock declared while motor not turning");

endmodule // bcs_speed_monitor

// file: bcs_motor_model.sv
`timescale 1ns/1ps
`include "bcs_consts.svh"

// ----------------------------------------
// Hall sensors, tachometer and reference source
// ----------------------------------------
module bcs_motor_model (
	input wire logic sys_clk,
	input wire logic [2:0] hall_state,
	input wire logic hall_tie,
	input wire logic [15:0] ref_half,
	input wire logic [15:0] tach_half,
	output logic [`BCS_HALL_W-1:0] hall_a_pos,
	output logic [`BCS_HALL_W-1:0] hall_a_neg,
	output logic [`BCS_HALL_W-1:0] hall_b_pos,
	output logic [`BCS_HALL_W-1:0] hall_b_neg,
	output logic [`BCS_HALL_W-1:0] hall_c_pos,
	output logic [`BCS_HALL_W-1:0] hall_c_neg,
	output logic reference_oscillator_input,
	output logic tach_pulse
);
	logic [15:0] ref_cnt;
	logic [15:0] tach_cnt;

	initial
	begin
		ref_cnt = 16'h0000;
		tach_cnt = 16'h0000;
		reference_oscillator_input = 1'b0;
		tach_pulse = 1'b0;
	end

	// Low phase is an equal pair when tied, so only a strict compare reads it low
	assign hall_a_pos = hall_state[0] ? 8'hA0 : (hall_tie ? 8'h80 : 8'h60);
	assign hall_a_neg = hall_state[0] ? 8'h60 : (hall_tie ? 8'h80 : 8'hA0);
	assign hall_b_pos = hall_state[1] ? 8'hA0 : (hall_tie ? 8'h80 : 8'h60);
	assign hall_b_neg = hall_state[1] ? 8'h60 : (hall_tie ? 8'h80 : 8'hA0);
	assign hall_c_pos = hall_state[2] ? 8'hA0 : (hall_tie ? 8'h80 : 8'h60);
	assign hall_c_neg = hall_state[2] ? 8'h60 : (hall_tie ? 8'h80 : 8'hA0);

	// A half period of zero stops the line low, as a motor at rest would
	always @(negedge sys_clk)
	begin
		if (ref_half == 16'h0000)
		begin
			ref_cnt <= 16'h0000;
			reference_oscillator_input <= 1'b0;
		end
		else if (ref_cnt >= ref_half - 16'h0001)
		begin
			ref_cnt <= 16'h0000;
			reference_oscillator_input <= ~reference_oscillator_input;
		end
		else
			ref_cnt <= ref_cnt + 16'h0001;
		if (tach_half == 16'h0000)
		begin
			tach_cnt <= 16'h0000;
			tach_pulse <= 1'b0;
		end
		else if (tach_cnt >= tach_half - 16'h0001)
		begin
			tach_cnt <= 16'h0000;
			tach_pulse <= ~tach_pulse;
		end
		else
			tach_cnt <= tach_cnt + 16'h0001;
	end
endmodule // bcs_motor_model

// file: tb_bldc_commutation_speed_ctrl.sv
`timescale 1ns/1ps
`include "bcs_consts.svh"

`define CHECK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin fail_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (act), (exp)); end end

module tb_bldc_commutation_speed_ctrl;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [2:0] hall_state = 3'h3;
	logic hall_tie = 1'b0;
	logic [15:0] ref_half = 16'h0000;
	logic [15:0] tach_half = 16'h0000;
	logic dir_reverse = 1'b0;
	logic [1:0] sel_a = 2'h0;
	logic [1:0] sel_b = 2'h0;
	logic [1:0] sel_c = 2'h0;
	logic [1:0] fb_sel = 2'h1;
	logic amp_node = 1'b1;
	logic clk_en = 1'b1;
	logic brake_command = 1'b0;
	logic [`BCS_HALL_W-1:0] hap, han, hbp, hbn, hcp, hcn;
	logic ref_in, tach;
	bcs_pkg::bcs_drive_e phase_drive_a, phase_drive_b, phase_drive_c;
	logic lock_out, lock_oe, pulse_out, pulse_oe, stop_mode, brake_active, taper;
	int fail_count = 0;
	int samples_checked = 0;

	always #2.5 sys_clk = ~sys_clk;

	bcs_motor_model motor (.sys_clk(sys_clk), .hall_state(hall_state), .hall_tie(hall_tie),
		.ref_half(ref_half), .tach_half(tach_half), .hall_a_pos(hap), .hall_a_neg(han),
		.hall_b_pos(hbp), .hall_b_neg(hbn), .hall_c_pos(hcp), .hall_c_neg(hcn),
		.reference_oscillator_input(ref_in), .tach_pulse(tach));

	bcs_top #(.STALL_CYCLES(24'h000FA0)) dut (.sys_clk(sys_clk), .resetn(resetn),
		.clk_en(clk_en), .hall_sense_a_pos(hap), .hall_sense_a_neg(han),
		.hall_sense_b_pos(hbp), .hall_sense_b_neg(hbn), .hall_sense_c_pos(hcp),
		.hall_sense_c_neg(hcn), .dir_reverse(dir_reverse), .divisor_select_a(sel_a),
		.divisor_select_b(sel_b), .divisor_select_c(sel_c),
		.reference_oscillator_input(ref_in), .speed_feedback_input(fb_sel),
		.speed_amp_output(amp_node), .tach_pulse(tach), .brake_command(brake_command),
		.phase_drive_a(phase_drive_a), .phase_drive_b(phase_drive_b),
		.phase_drive_c(phase_drive_c), .lock_indicator_out(lock_out),
		.lock_indicator_oe(lock_oe), .speed_pulse_output_out(pulse_out),
		.speed_pulse_output_oe(pulse_oe), .stop_mode(stop_mode),
		.brake_active(brake_active), .brake_taper_threshold(taper));

	wire [5:0] drives = {phase_drive_a, phase_drive_b, phase_drive_c};

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [5:0] exp_drive(input logic [2:0] h, input logic rev);
		logic [5:0] d;
		case (h)
			3'h3: d = 6'h06;
			3'h1: d = 6'h12;
			3'h5: d = 6'h18;
			3'h4: d = 6'h09;
			3'h6: d = 6'h21;
			3'h2: d = 6'h24;
			default: d = 6'h00;
		endcase
		return rev ? {d[4], d[5], d[2], d[3], d[0], d[1]} : d;
	endfunction

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask

	task automatic wait_oe(input logic exp, input int limit);
		for (int i = 0; i < limit && lock_oe !== exp; i++)
			@(negedge sys_clk);
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_commutation();
		for (int r = 0; r < 2; r++)
			for (int h = 0; h < 8; h++)
			begin
				hall_state = 3'(h);
				dir_reverse = 1'(r);
				settle(2);
				`CHECK(drives, exp_drive(3'(h), 1'(r)))
			end
		dir_reverse = 1'b0;
		hall_state = 3'h1;
		hall_tie = 1'b1;
		settle(2);
		`CHECK(drives, 6'h12)
		// Clock enable low freezes the drive pattern
		clk_en = 1'b0;
		hall_state = 3'h5;
		settle(3);
		`CHECK(drives, 6'h12)
		clk_en = 1'b1;
		hall_tie = 1'b0;
		$display("test commutation done");
	endtask

	task automatic test_stop();
		hall_state = 3'h3;
		brake_command = 1'b1;
		amp_node = 1'b0;
		settle(2);
		`CHECK({stop_mode, brake_active, drives}, 8'h80)
		// free-run start from a released brake
		brake_command = 1'b0;
		settle(1);
		amp_node = 1'b1;
		settle(2);
		`CHECK({stop_mode, drives}, 7'h06)
		$display("test stop done");
	endtask

	task automatic test_feedback();
		hall_state = 3'h1;
		settle(4);
		`CHECK({pulse_oe, pulse_out}, 2'h2)
		fb_sel = 2'h2;
		settle(4);
		`CHECK(pulse_oe, 1'b0)
		hall_state = 3'h2;
		settle(4);
		`CHECK(pulse_oe, 1'b1)
		fb_sel = 2'h0;
		tach_half = 16'h0003;
		settle(4);
		repeat (40)
		begin
			settle(0);
			`CHECK(pulse_oe, 1'b0)
		end
		hall_state = 3'h6;
		settle(2);
		`CHECK(pulse_oe, 1'b1)
		tach_half = 16'h0000;
		fb_sel = 2'h1;
		$display("test feedback done");
	endtask

	task automatic test_lock();
		logic [1:0] ta [4] = '{2'h0, 2'h0, 2'h0, 2'h1};
		logic [1:0] tb [4] = '{2'h1, 2'h1, 2'h1, 2'h0};
		logic [1:0] tc [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
		logic [15:0] th [4] = '{16'h0200, 16'h0200, 16'h0200, 16'h0600};
		logic te [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
		hall_state = 3'h3;
		ref_half = 16'h0014;
		tach_half = 16'h0014;
		wait_oe(1'b1, 3000);
		`CHECK({lock_oe, lock_out}, 2'h2)
		for (int i = 0; i < 4; i++)
		begin
			sel_a = ta[i];
			sel_b = tb[i];
			sel_c = tc[i];
			ref_half = 16'h0001;
			tach_half = th[i];
			if (te[i])
				wait_oe(1'b1, 14000);
			else
				settle(8000);
			`CHECK(lock_oe, te[i])
		end
		$display("test lock done");
	endtask

	task automatic test_brake();
		int n;
		sel_a = 2'h0;
		sel_b = 2'h0;
		ref_half = 16'h0014;
		tach_half = 16'h0014;
		// Lock may still stand from the slow rate; let both periods settle first
		settle(400);
		wait_oe(1'b1, 4000);
		`CHECK(lock_oe, 1'b1)
		brake_command = 1'b1;
		settle(2);
		`CHECK({brake_active, drives}, {1'b1, exp_drive(3'h3, 1'b1)})
		tach_half = 16'h0000;
		n = 0;
		while (taper !== 1'b1 && n < 3000)
		begin
			settle(0);
			n++;
		end
		`CHECK(n > 1200 && n < 1400, 1'b1)
		`CHECK(drives, exp_drive(3'h3, 1'b1))
		for (n = 0; n < 5000 && drives !== 6'h00; n++)
			settle(0);
		`CHECK({brake_active, drives}, 7'h40)
		brake_command = 1'b0;
		settle(2);
		`CHECK({brake_active, drives}, 7'h06)
		$display("test brake done");
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		repeat (10) @(negedge sys_clk);
		`CHECK({drives, lock_oe, stop_mode, brake_active}, 9'h000)
		repeat (2) @(negedge sys_clk);
		resetn = 1'b1;
		test_commutation();
		test_stop();
		test_feedback();
		test_lock();
		test_brake();
		stop_test();
	end

	initial
	begin
		repeat (90000) @(posedge sys_clk);
		fail_count++;
		stop_test();
	end
endmodule // tb_bldc_commutation_speed_ctrl
